// [design/eel_top.sv]
// top: eee lpi status/control register bank on apb with lpi request gating
//
// Summary of operation
// - in fiber mode eee and live lpi status read zero, lpi latches do not set (a held one stays), and lpi is held off.
// - bit 14 shows 100base-tx eee enabled by hardware next-page exchange.
// - bit 13 latches tx pcs lpi seen; cleared by writing one.
// - bit 12 shows tx pcs lpi live, no latching.
// - bit 11 latches rx pcs lpi seen; cleared by writing one.
// - bit 10 shows rx pcs lpi live, no latching.
// - bit 6 read-only one: next-page location given by bit 5.
// - bit 5 read-only one: next pages go to dedicated receive register.
// - bit 4 latches parallel detection fault, cleared by reading the register.
// - bit 3 shows link partner next-page ability.
// - bit 2 shows local next-page ability, default one.
// - bit 1 latches when a new page arrives from the link partner.
// - bit 0 shows link partner auto-negotiation ability.
// - after lpi ends, transmit is held for count times 640 ns, default 0x27.
// - control bit 7 set lets input traffic cancel a pending lpi request.
// - buffer usage above 6-bit threshold of 512-byte units ends lpi.
// - next-page enable bit 8 cleared skips next-page exchange, disabling eee.
`timescale 1ns/1ps
`default_nettype none
module eel_top #(
  parameter int UNIT_CYC = eel_pkg::UNIT_CYC
) (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire logic                   psel,
  input  wire logic                   penable,
  input  wire logic                   pwrite,
  input  wire logic [13:0]            paddr,
  input  wire logic [31:0]            pwdata,
  input  wire logic [3:0]             pstrb,
  output logic      [31:0]            prdata,
  output logic                        pready,
  output logic                        pslverr,
  input  wire logic                   fiber_mode,
  input  wire eel_pkg::eel_phy_stat_t phy_stat,
  input  wire eel_pkg::eel_mac_in_t   mac_in,
  output logic                        lpi_req_out,
  output logic                        tx_hold,
  output logic                        np_enable
);
  logic        tx_lat_r;
  logic        rx_lat_r;
  logic        pd_lat_r;
  logic        pg_lat_r;
  logic [7:0]  recovery_r;
  logic [5:0]  thresh_r;
  logic        traffic_en_r;
  logic        np_en_r;
  logic [1:0]  rsvd98_r;
  logic        rsvd15_r;
  logic        lpi_prev_r;
  logic        access;
  logic        wr;
  logic        rd;
  logic        copper;
  logic [15:0] status_word;
  logic [31:0] rdata_nxt;
  logic        mapped;
  logic        timer_busy;
  logic        lpi_exit_ev;
  logic        buf_over;
  logic [15:0] hold_len_r;
  logic [15:0] hold_want_r;

  // one-word-per-register decode, used by reads and writes alike
  function automatic logic hit(input logic [13:0] a, input logic [13:0] base);
    return a == base;
  endfunction

  assign access = psel && penable && pready;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign copper = !fiber_mode;
  assign mapped = hit(paddr, eel_pkg::BADDR_STATUS) || hit(paddr, eel_pkg::BADDR_RECOVERY)
               || hit(paddr, eel_pkg::BADDR_BUFCTL);

  // pready rises in the access phase: one wait state per transfer
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      pready  <= psel && penable && !pready;
      pslverr <= psel && penable && !pready && !mapped;
    end
  end

  // status word assembly; fiber mode blanks bit 14 and the live lpi bits, not the lpi latches
  always_comb begin
    status_word                          = 16'h0000;
    status_word[eel_pkg::B_STAT_RSVD15]  = rsvd15_r;
    status_word[9:8]                     = rsvd98_r;
    status_word[eel_pkg::B_HW_EEE]       = copper && phy_stat.hw_eee_en;
    status_word[eel_pkg::B_TX_LPI_LATCH] = tx_lat_r;
    status_word[eel_pkg::B_TX_LPI_LIVE]  = copper && phy_stat.tx_lpi;
    status_word[eel_pkg::B_RX_LPI_LATCH] = rx_lat_r;
    status_word[eel_pkg::B_RX_LPI_LIVE]  = copper && phy_stat.rx_lpi;
    status_word[eel_pkg::B_NP_LOC_ABLE]  = 1'b1;
    status_word[eel_pkg::B_NP_LOC]       = 1'b1;
    status_word[eel_pkg::B_PD_FAULT]     = pd_lat_r;
    status_word[eel_pkg::B_LP_NP_ABLE]   = phy_stat.lp_np_able;
    status_word[eel_pkg::B_NP_ABLE]      = 1'b1;
    status_word[eel_pkg::B_PAGE_RX]      = pg_lat_r;
    status_word[eel_pkg::B_LP_AN_ABLE]   = phy_stat.lp_an_able;
  end

  always_comb begin
    rdata_nxt = 32'h0000_0000;
    if (hit(paddr, eel_pkg::BADDR_STATUS)) begin
      rdata_nxt[15:0] = status_word;
    end else if (hit(paddr, eel_pkg::BADDR_RECOVERY)) begin
      rdata_nxt[7:0] = recovery_r;
    end else if (hit(paddr, eel_pkg::BADDR_BUFCTL)) begin
      rdata_nxt[eel_pkg::B_TRAFFIC_EN] = traffic_en_r;
      rdata_nxt[5:0]                   = thresh_r;
      rdata_nxt[eel_pkg::B_NP_ENABLE]  = np_en_r;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      prdata <= 32'h0000_0000;
    end else if (psel && penable && !pready && !pwrite) begin
      prdata <= rdata_nxt;
    end
  end

  // latched lpi flags: hardware set beats the write-one clear
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_lat_r <= 1'b0;
      rx_lat_r <= 1'b0;
    end else begin
      if (copper && phy_stat.tx_lpi) begin
        tx_lat_r <= 1'b1;
      end else if (wr && hit(paddr, eel_pkg::BADDR_STATUS) && pstrb[1]
                   && pwdata[eel_pkg::B_TX_LPI_LATCH]) begin
        tx_lat_r <= 1'b0;
      end
      if (copper && phy_stat.rx_lpi) begin
        rx_lat_r <= 1'b1;
      end else if (wr && hit(paddr, eel_pkg::BADDR_STATUS) && pstrb[1]
                   && pwdata[eel_pkg::B_RX_LPI_LATCH]) begin
        rx_lat_r <= 1'b0;
      end
    end
  end

  // read-clear flags: a new event in the read cycle stays set
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pd_lat_r <= 1'b0;
      pg_lat_r <= 1'b0;
    end else begin
      if (phy_stat.pd_fault) begin
        pd_lat_r <= 1'b1;
      end else if (rd && hit(paddr, eel_pkg::BADDR_STATUS)) begin
        pd_lat_r <= 1'b0;
      end
      if (phy_stat.page_rx) begin
        pg_lat_r <= 1'b1;
      end else if (rd && hit(paddr, eel_pkg::BADDR_STATUS)) begin
        pg_lat_r <= 1'b0;
      end
    end
  end

  // writable control fields, byte-lane qualified
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      recovery_r   <= eel_pkg::RECOVERY_RST;
      thresh_r     <= eel_pkg::THRESH_RST;
      traffic_en_r <= eel_pkg::TRAFFIC_RST;
      np_en_r      <= eel_pkg::NP_ENABLE_RST;
      rsvd98_r     <= eel_pkg::RSVD98_RST;
      rsvd15_r     <= eel_pkg::RSVD15_RST;
    end else if (wr) begin
      if (hit(paddr, eel_pkg::BADDR_STATUS) && pstrb[1]) begin
        rsvd98_r <= pwdata[9:8];
        rsvd15_r <= pwdata[eel_pkg::B_STAT_RSVD15];
      end
      if (hit(paddr, eel_pkg::BADDR_RECOVERY) && pstrb[0]) begin
        recovery_r <= pwdata[7:0];
      end
      if (hit(paddr, eel_pkg::BADDR_BUFCTL) && pstrb[0]) begin
        traffic_en_r <= pwdata[eel_pkg::B_TRAFFIC_EN];
        thresh_r     <= pwdata[5:0];
      end
      if (hit(paddr, eel_pkg::BADDR_BUFCTL) && pstrb[1]) begin
        np_en_r <= pwdata[eel_pkg::B_NP_ENABLE];
      end
    end
  end

  // buffer usage in bytes compared with threshold times 512
  assign buf_over = mac_in.buf_used > (16'(thresh_r) * 16'(eel_pkg::BUF_UNIT_BYTES));

  // lpi request gating; fiber mode, np disabled, overload or traffic cancel it
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      lpi_req_out <= 1'b0;
      np_enable   <= eel_pkg::NP_ENABLE_RST;
      lpi_prev_r  <= 1'b0;
    end else begin
      np_enable   <= np_en_r;
      lpi_req_out <= mac_in.lpi_req && copper && np_en_r && !buf_over
                   && !(traffic_en_r && mac_in.traffic);
      lpi_prev_r  <= lpi_req_out;
    end
  end

  assign lpi_exit_ev = (lpi_prev_r && !lpi_req_out) || mac_in.lpi_exit;

  eel_wait_timer #(
    .UNIT_CYC (UNIT_CYC)
  ) u_timer (
    .clk   (clk),
    .rst_n (rst_n),
    .start (lpi_exit_ev),
    .units (recovery_r),
    .busy  (timer_busy)
  );

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_hold <= 1'b0;
    end else begin
      tx_hold <= timer_busy || lpi_exit_ev;
    end
  end

  // length of the running transmit hold; a restart mid-hold begins a new count
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hold_len_r  <= 16'h0000;
      hold_want_r <= 16'h0000;
    end else if (lpi_exit_ev) begin
      hold_len_r  <= 16'h0000;
      hold_want_r <= 16'(recovery_r) * 16'(UNIT_CYC) + 16'h0001;
    end else if (tx_hold) begin
      hold_len_r <= hold_len_r + 16'h0001;
    end
  end

  property p_fiber_blank;
    @(posedge clk) disable iff (!rst_n)
      fiber_mode |=> !lpi_req_out;
  endproperty
  a_fiber_blank: assert property (p_fiber_blank) else $error("lpi request in fiber mode");

  property p_tx_latch;
    @(posedge clk) disable iff (!rst_n)
      (copper && phy_stat.tx_lpi) |=> tx_lat_r;
  endproperty
  a_tx_latch: assert property (p_tx_latch) else $error("tx lpi latch missed");

  property p_rx_hold;
    @(posedge clk) disable iff (!rst_n)
      (rx_lat_r && !wr) |=> rx_lat_r;
  endproperty
  a_rx_hold: assert property (p_rx_hold) else $error("rx lpi latch dropped");

  property p_pd_clear;
    @(posedge clk) disable iff (!rst_n)
      (rd && hit(paddr, eel_pkg::BADDR_STATUS) && !phy_stat.pd_fault) |=> !pd_lat_r;
  endproperty
  a_pd_clear: assert property (p_pd_clear) else $error("fault flag not cleared on read");

  property p_pg_set;
    @(posedge clk) disable iff (!rst_n)
      phy_stat.page_rx |=> pg_lat_r;
  endproperty
  a_pg_set: assert property (p_pg_set) else $error("page received not latched");

  property p_traffic;
    @(posedge clk) disable iff (!rst_n)
      (traffic_en_r && mac_in.traffic) |=> !lpi_req_out;
  endproperty
  a_traffic: assert property (p_traffic) else $error("traffic did not stop lpi");

  property p_buf;
    @(posedge clk) disable iff (!rst_n)
      buf_over |=> !lpi_req_out;
  endproperty
  a_buf: assert property (p_buf) else $error("buffer overload did not end lpi");

  property p_hold;
    @(posedge clk) disable iff (!rst_n)
      (lpi_exit_ev && recovery_r != 8'h00) |=> tx_hold [*2];
  endproperty
  a_hold: assert property (p_hold) else $error("transmit hold too short");

  property p_np;
    @(posedge clk) disable iff (!rst_n)
      !np_en_r |=> (!np_enable && !lpi_req_out);
  endproperty
  a_np: assert property (p_np) else $error("next page disable ignored");

  property p_hold_len;
    @(posedge clk) disable iff (!rst_n)
      $fell(tx_hold) |-> (hold_len_r == hold_want_r);
  endproperty
  a_hold_len: assert property (p_hold_len) else $error("transmit hold length wrong");

  property p_tx_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr && hit(paddr, eel_pkg::BADDR_STATUS) && pstrb[1]
       && pwdata[eel_pkg::B_TX_LPI_LATCH] && !(copper && phy_stat.tx_lpi)) |=> !tx_lat_r;
  endproperty
  a_tx_clear: assert property (p_tx_clear) else $error("tx lpi latch not cleared");

  property p_rx_clear;
    @(posedge clk) disable iff (!rst_n)
      (wr && hit(paddr, eel_pkg::BADDR_STATUS) && pstrb[1]
       && pwdata[eel_pkg::B_RX_LPI_LATCH] && !(copper && phy_stat.rx_lpi)) |=> !rx_lat_r;
  endproperty
  a_rx_clear: assert property (p_rx_clear) else $error("rx lpi latch not cleared");

  property p_rx_set;
    @(posedge clk) disable iff (!rst_n)
      (copper && phy_stat.rx_lpi) |=> rx_lat_r;
  endproperty
  a_rx_set: assert property (p_rx_set) else $error("rx lpi latch missed");

  property p_fiber_latch;
    @(posedge clk) disable iff (!rst_n)
      (fiber_mode && !tx_lat_r && !rx_lat_r) |=> (!tx_lat_r && !rx_lat_r);
  endproperty
  a_fiber_latch: assert property (p_fiber_latch) else $error("lpi latch set in fiber mode");

  property p_pg_clear;
    @(posedge clk) disable iff (!rst_n)
      (rd && hit(paddr, eel_pkg::BADDR_STATUS) && !phy_stat.page_rx) |=> !pg_lat_r;
  endproperty
  a_pg_clear: assert property (p_pg_clear) else $error("page flag not cleared on read");

  property p_pd_set;
    @(posedge clk) disable iff (!rst_n)
      phy_stat.pd_fault |=> pd_lat_r;
  endproperty
  a_pd_set: assert property (p_pd_set) else $error("fault not latched");

  property p_const_bits;
    @(posedge clk) disable iff (!rst_n)
      (rd && hit(paddr, eel_pkg::BADDR_STATUS)) |-> (prdata[6:5] == 2'b11 && prdata[2]);
  endproperty
  a_const_bits: assert property (p_const_bits) else $error("constant status bits wrong");
endmodule
`default_nettype wire

// [design/eel_pkg.sv]
// package: register map, field positions, reset values and timing for the eee lpi block
package eel_pkg;
  localparam logic [11:0] ADDR_STATUS    = 12'h0E4;
  localparam logic [11:0] ADDR_RECOVERY  = 12'h0E6;
  localparam logic [11:0] ADDR_BUFCTL    = 12'h0E7;
  // byte addresses on apb: each register in its own aligned word (index * 4)
  localparam logic [13:0] BADDR_STATUS   = {ADDR_STATUS, 2'b00};
  localparam logic [13:0] BADDR_RECOVERY = {ADDR_RECOVERY, 2'b00};
  localparam logic [13:0] BADDR_BUFCTL   = {ADDR_BUFCTL, 2'b00};

  localparam int B_HW_EEE       = 14;
  localparam int B_TX_LPI_LATCH = 13;
  localparam int B_TX_LPI_LIVE  = 12;
  localparam int B_RX_LPI_LATCH = 11;
  localparam int B_RX_LPI_LIVE  = 10;
  localparam int B_NP_LOC_ABLE  = 6;
  localparam int B_NP_LOC       = 5;
  localparam int B_PD_FAULT     = 4;
  localparam int B_LP_NP_ABLE   = 3;
  localparam int B_NP_ABLE      = 2;
  localparam int B_PAGE_RX      = 1;
  localparam int B_LP_AN_ABLE   = 0;
  localparam int B_STAT_RSVD15  = 15;
  localparam int B_TRAFFIC_EN   = 7;
  localparam int B_NP_ENABLE    = 8;

  localparam logic [7:0] RECOVERY_RST  = 8'h27;
  localparam logic [5:0] THRESH_RST    = 6'h08;
  localparam logic       TRAFFIC_RST   = 1'b0;
  localparam logic       NP_ENABLE_RST = 1'b1;
  localparam logic [1:0] RSVD98_RST    = 2'h0;
  localparam logic       RSVD15_RST    = 1'b1;

  localparam int CLK_PERIOD_PS  = 8000;
  localparam int UNIT_PS        = 640000;
  // one recovery count unit in clocks (640 ns / 8 ns)
  localparam int UNIT_CYC       = (UNIT_PS + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;
  localparam int BUF_UNIT_BYTES = 512;

  typedef struct packed {
    logic hw_eee_en;
    logic tx_lpi;
    logic rx_lpi;
    logic pd_fault;
    logic lp_np_able;
    logic page_rx;
    logic lp_an_able;
  } eel_phy_stat_t;

  typedef struct packed {
    logic        lpi_req;
    logic        traffic;
    logic        lpi_exit;
    logic [15:0] buf_used;
  } eel_mac_in_t;
endpackage

// [design/eel_wait_timer.sv]
// recovery wait timer: counts programmed 640 ns units after lpi ends
`timescale 1ns/1ps
`default_nettype none
module eel_wait_timer #(
  parameter int UNIT_CYC = eel_pkg::UNIT_CYC
) (
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       start,
  input  wire logic [7:0] units,
  output logic            busy
);
  localparam int CW = $clog2(UNIT_CYC + 1);
  logic [CW-1:0] cyc_r;
  logic [7:0]    unit_r;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cyc_r  <= '0;
      unit_r <= 8'h00;
      busy   <= 1'b0;
    end else if (start) begin
      cyc_r  <= CW'(UNIT_CYC - 1);
      unit_r <= units;
      busy   <= (units != 8'h00);
    end else if (busy) begin
      if (cyc_r != '0) begin
        cyc_r <= cyc_r - CW'(1);
      end else if (unit_r <= 8'h01) begin
        busy   <= 1'b0;
        unit_r <= 8'h00;
      end else begin
        unit_r <= unit_r - 8'h01;
        cyc_r  <= CW'(UNIT_CYC - 1);
      end
    end
  end
endmodule
`default_nettype wire

// [test/eel_partner.sv]
// link partner model: drives phy status levels and turns page and fault requests into events
`timescale 1ns/1ps
`default_nettype none
module eel_partner (
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  input  wire eel_pkg::eel_phy_stat_t want,
  output var  eel_pkg::eel_phy_stat_t phy_stat
);
  logic pg_r;
  logic pf_r;
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phy_stat <= '0;
      pg_r     <= 1'b0;
      pf_r     <= 1'b0;
    end else begin
      pg_r     <= want.page_rx;
      pf_r     <= want.pd_fault;
      // a new page or a fault is one event, so the latch must hold it after the pulse
      phy_stat <= eel_pkg::eel_phy_stat_t'(want & ~{3'b000, pf_r, 1'b0, pg_r, 1'b0});
    end
  end
endmodule
`default_nettype wire

// [test/tb_eel_top.sv]
// testbench: apb register checks, lpi gating and recovery hold of the eee lpi block
`timescale 1ns/1ps
`default_nettype none
module tb_eel_top;
  localparam int          UC  = 2;
  localparam logic [32:0] ALL = 33'h1FFFFFFFF;
  localparam logic [13:0] STA = eel_pkg::BADDR_STATUS;
  localparam logic [13:0] REC = eel_pkg::BADDR_RECOVERY;
  localparam logic [13:0] BUF = eel_pkg::BADDR_BUFCTL;
  logic                   clk;
  logic                   rst_n;
  logic                   psel;
  logic                   penable;
  logic                   pwrite;
  logic [13:0]            paddr;
  logic [31:0]            pwdata;
  logic [31:0]            prdata;
  logic                   pready;
  logic                   pslverr;
  logic                   fiber;
  eel_pkg::eel_phy_stat_t want;
  eel_pkg::eel_phy_stat_t phy;
  eel_pkg::eel_mac_in_t   mac;
  logic                   lpi_req_out;
  logic                   tx_hold;
  logic                   np_enable;
  logic [32:0]            qe[$];
  logic [32:0]            qm[$];
  int                     errors;
  int                     checks_done;
  int                     cyc = 0;
  int                     seed;
  int                     n;

  eel_top #(.UNIT_CYC(UC)) dut (
    .clk(clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fiber_mode(fiber), .phy_stat(phy), .mac_in(mac),
    .lpi_req_out(lpi_req_out), .tx_hold(tx_hold), .np_enable(np_enable));
  eel_partner lp (.clk(clk), .rst_n(rst_n), .want(want), .phy_stat(phy));

  task automatic check(input string nm, input logic [32:0] seen, input logic [32:0] exp);
    checks_done++;
    if (seen !== exp) begin
      errors++;
      $display("BAD %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic conclude();
    if (errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // e and m carry {pslverr, prdata}; the monitor compares under the mask
  task automatic apb(input logic w, input logic [13:0] a, input logic [31:0] d,
                     input logic [32:0] e, input logic [32:0] m);
    qe.push_back(e);
    qm.push_back(m);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    @(posedge clk);
    // only the bench timeout ends a wait for pready
    while (pready !== 1'b1) begin
      @(posedge clk);
    end
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clk);
  endtask

  task automatic rd(input logic [13:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, {1'b0, e}, ALL);
  endtask

  task automatic wr(input logic [13:0] a, input logic [31:0] d);
    apb(1'b1, a, d, 33'h0, {1'b1, 32'h0});
  endtask

  task automatic tick(input int c);
    repeat (c) @(posedge clk);
  endtask

  task automatic lpi(input logic e);
    tick(3);
    check("lpi_req_out", 33'(lpi_req_out), 33'(e));
  endtask

  task automatic hold(input logic [7:0] cnt);
    wr(REC, {24'h0, cnt});
    mac.lpi_exit <= 1'b1;
    @(posedge clk);
    mac.lpi_exit <= 1'b0;
    n = 0;
    repeat (UC * cnt + 20) begin
      @(posedge clk);
      if (tx_hold === 1'b1) n++;
    end
    check("tx_hold cycles", 33'(n >= UC * cnt && n <= UC * cnt + 3), 33'h1);
  endtask

  always @(posedge clk) begin
    if (psel && penable && pready === 1'b1) begin
      check("apb", {pslverr, prdata} & qm[0], qe[0] & qm[0]);
      void'(qe.pop_front());
      void'(qm.pop_front());
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      conclude();
    end
  end

  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end

  initial begin
    seed = 21555;
    errors = 0;
    checks_done = 0;
    rst_n = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = '0;
    pwdata = '0;
    fiber = 1'b0;
    want = '0;
    mac = '0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    check("np_enable", 33'(np_enable), 33'h1);
    rd(STA, 32'h8064);
    rd(REC, 32'h27);
    rd(BUF, 32'h108);
    apb(1'b0, 14'h3A0, 32'h0, {1'b1, 32'h0}, ALL);
    want <= 7'b1110101;
    tick(3);
    rd(STA, 32'hFC6D);
    want <= 7'b1000101;
    tick(3);
    rd(STA, 32'hE86D);
    wr(STA, 32'hA800);
    rd(STA, 32'hC06D);
    want <= 7'b1001111;
    tick(3);
    rd(STA, 32'hC07F);
    rd(STA, 32'hC06D);
    // fiber: live and latched eee status stay quiet, lpi held off
    fiber <= 1'b1;
    want <= 7'b1110101;
    mac.lpi_req <= 1'b1;
    lpi(1'b0);
    apb(1'b0, STA, 32'h0, 33'h0, 33'h7C00);
    want <= '0;
    tick(2);
    fiber <= 1'b0;
    mac.buf_used <= 16'($unsigned($random(seed)) % 4097);
    lpi(1'b1);
    mac.traffic <= 1'b1;
    lpi(1'b1);
    wr(BUF, 32'h188);
    lpi(1'b0);
    wr(BUF, 32'h108);
    mac.buf_used <= 16'd4096;
    lpi(1'b1);
    mac.buf_used <= 16'd4097;
    lpi(1'b0);
    wr(BUF, 32'h03F);
    lpi(1'b0);
    check("np_enable", 33'(np_enable), 33'h0);
    wr(BUF, 32'h13F);
    lpi(1'b1);
    // the fall of the request also starts a hold, so let the default count run out
    mac.lpi_req <= 1'b0;
    tick(120);
    hold(8'h03);
    hold(8'h00);
    rd(REC, 32'h0);
    conclude();
  end
endmodule
`default_nettype wire
